// ---- pkg/fhf_pkg.sv ----
package fhf_pkg;

    // ********************************
    // widths and register file
    // ********************************
    localparam int REG_W  = 32;             // float register width
    localparam int NREG   = 8;              // float registers
    localparam int RIDX_W = 3;              // register index width
    localparam int NSTAGE = 5;              // R1, R2, E1, E2, E3
    localparam int STG_R1 = 0;              // first read stage
    localparam int STG_R2 = 1;              // second read stage, operands taken here
    localparam int STG_E3 = 4;              // final execute stage, result written on exit

    // ********************************
    // operations
    // ********************************
    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,                     // empty slot
        OP_LOAD = 4'h1,                     // dst <= data
        OP_MUL  = 4'h2,                     // float_multiply_op
        OP_ADD  = 4'h3,                     // float_add_op
        OP_MOVE = 4'h4,                     // register_move_op, src a to the cpu
        OP_RCP  = 4'h5,                     // reciprocal_estimate_op
        OP_ISQ  = 4'h6,                     // inv_sqrt_estimate_op
        OP_STW  = 4'h7                      // float_status_register <= data
    } fhf_op_e;

    // ********************************
    // float_status_register layout
    // ********************************
    localparam int         ST_LUF = 0;      // latched underflow
    localparam int         ST_LVF = 1;      // latched overflow
    localparam int         ST_W   = 2;
    localparam logic [1:0] ST_RST = 2'h0;

    // ********************************
    // timing
    // ********************************
    localparam logic [2:0] DELAY_SLOTS = 3'h3;   // slots after a multiply or add

    // ********************************
    // controller register map (apb byte addresses)
    // ********************************
    localparam logic [7:0] A_CMD     = 8'h00;
    localparam logic [7:0] A_DATA    = 8'h04;
    localparam logic [7:0] A_RESULT  = 8'h08;
    localparam logic [7:0] A_STATUS  = 8'h0C;
    localparam logic [7:0] A_IRQSTAT = 8'h10;
    localparam logic [7:0] A_IRQMASK = 8'h14;
    localparam int CMD_OP_LSB  = 0;         // cmd fields
    localparam int CMD_DST_LSB = 4;
    localparam int CMD_SA_LSB  = 8;
    localparam int CMD_SB_LSB  = 12;
    localparam int IRQ_W    = 4;            // irq status and mask layout
    localparam int IRQ_MOVE = 0;
    localparam int IRQ_LUF  = 1;
    localparam int IRQ_LVF  = 2;
    localparam int IRQ_REF  = 3;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

    // one pipeline slot
    typedef struct packed {
        logic              v;
        fhf_op_e           op;
        logic [RIDX_W-1:0] dst;
        logic [RIDX_W-1:0] sa;
        logic [RIDX_W-1:0] sb;
        logic [REG_W-1:0]  a;
        logic [REG_W-1:0]  b;
    } fhf_stage_s;

    // op writes a float register
    function automatic logic fhf_writes(input fhf_op_e op);
        return op inside {OP_LOAD, OP_MUL, OP_ADD, OP_RCP, OP_ISQ};
    endfunction

    // op is one of the two estimates
    function automatic logic fhf_is_est(input fhf_op_e op);
        return op inside {OP_RCP, OP_ISQ};
    endfunction

endpackage

// ---- pkg/fhf_link_if.sv ----
`timescale 1ns/1ps
interface fhf_link_if;
    import fhf_pkg::*;
    logic              issueValid;          // cpu offers an instruction
    fhf_op_e           issueOp;
    logic [RIDX_W-1:0] issueDst;
    logic [RIDX_W-1:0] issueSrcA;
    logic [RIDX_W-1:0] issueSrcB;
    logic [REG_W-1:0]  issueData;
    logic              e3Hold;              // cpu-side stall of the final execute stage
    logic              issueAck;            // one-cycle take pulse
    logic              retireValid;         // one-cycle pulse, instruction left E3
    fhf_op_e           retireOp;
    logic [REG_W-1:0]  moveData;
    logic [ST_W-1:0]   floatStatus;         // latched flags, also the interrupt lines

    modport dev (input issueValid, issueOp, issueDst, issueSrcA, issueSrcB, issueData,
                 e3Hold, output issueAck, retireValid, retireOp, moveData, floatStatus);
    modport cpu (output issueValid, issueOp, issueDst, issueSrcA, issueSrcB, issueData,
                 e3Hold, input issueAck, retireValid, retireOp, moveData, floatStatus);
endinterface

// ---- rtl/fhf_fpu_pipe.sv ----
`timescale 1ns/1ps
module fhf_fpu_pipe
    import fhf_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    fhf_link_if.dev   lnk
);

    // ********************************
    // state
    // ********************************
    fhf_stage_s       stg [NSTAGE];         // R1 .. E3
    logic [REG_W-1:0] rf  [NREG];           // float registers

    // integer square root, used by the inverse square root estimate
    function automatic logic [15:0] isqrt(input logic [REG_W-1:0] x);
        logic [15:0] r;
        logic [15:0] t;
        r = 16'h0;
        for (int i = 15; i >= 0; i--) begin
            t = r | (16'h1 << i);
            if ({16'h0, t} * {16'h0, t} <= x) begin
                r = t;
            end
        end
        return r;
    endfunction

    // ********************************
    // stall and hazard decode
    // ********************************
    wire hold = stg[STG_E3].v & lnk.e3Hold;
    wire rdA  = stg[STG_R1].op inside {OP_MUL, OP_ADD, OP_MOVE, OP_RCP, OP_ISQ};
    wire rdB  = stg[STG_R1].op inside {OP_MUL, OP_ADD};
    logic hazard;
    // a consumer waits in R1 while any writer of its source sits in R2..E2;
    // a writer in E3 either leaves this edge (write-first read) or freezes all
    always_comb begin
        hazard = 1'b0;
        for (int k = STG_R2; k < STG_E3; k++) begin
            if (stg[k].v && fhf_writes(stg[k].op) &&
                ((rdA && stg[k].dst == stg[STG_R1].sa) ||
                 (rdB && stg[k].dst == stg[STG_R1].sb))) begin
                hazard = 1'b1;
            end
        end
    end
    wire advR1 = stg[STG_R1].v & ~hazard;
    wire take  = lnk.issueValid & ~lnk.issueAck & ~hold & (~stg[STG_R1].v | advR1);

    // ********************************
    // result of the instruction in E3
    // ********************************
    wire [REG_W-1:0]   ea   = stg[STG_E3].a;
    wire [REG_W-1:0]   eb   = stg[STG_E3].b;
    wire [2*REG_W-1:0] prod = {32'h0, ea} * {32'h0, eb};
    wire [REG_W:0]     sum  = {1'b0, ea} + {1'b0, eb};
    wire [15:0]        sq   = isqrt(ea);
    wire [REG_W-1:0]   rcp  = (ea == 32'h0) ? 32'hFFFF_FFFF : 32'hFFFF_FFFF / ea;
    wire [REG_W-1:0]   irs  = (sq == 16'h0) ? 32'hFFFF_FFFF : 32'hFFFF_FFFF / {16'h0, sq};
    logic [REG_W-1:0]  res;
    logic [ST_W-1:0]   flg;
    // estimates give correct values; their flag effect is not meaningful
    always_comb begin
        res = ea;
        flg = 2'h0;
        case (stg[STG_E3].op)
            OP_MUL: begin
                res = prod[REG_W-1:0];
                flg = {prod[2*REG_W-1:REG_W] != 32'h0,
                       ea != 32'h0 && eb != 32'h0 && prod == 64'h0};
            end
            OP_ADD: begin
                res = sum[REG_W-1:0];
                flg = {sum[REG_W], 1'b0};
            end
            OP_RCP:  begin
                res = rcp;
                // defective flag path: flags follow stray result bits
                flg = {rcp[REG_W-1], rcp[0]};
            end
            OP_ISQ:  begin
                res = irs;
                flg = {irs[REG_W-1], irs[0]};
            end
            default: begin
                res = ea;
                flg = 2'h0;
            end
        endcase
    end
    wire             leave = stg[STG_E3].v & ~hold;
    wire             wbEn  = leave & fhf_writes(stg[STG_E3].op);
    wire [RIDX_W-1:0] wbDst = stg[STG_E3].dst;
    // write-first read: a consumer entering R2 on the producer's exit edge sees the product
    wire [REG_W-1:0] rfA = (wbEn && wbDst == stg[STG_R1].sa) ? res : rf[stg[STG_R1].sa];
    // loads and status writes carry their own data in operand a, so keep it
    wire [REG_W-1:0] opA = rdA ? rfA : stg[STG_R1].a;
    wire [REG_W-1:0] opB = (wbEn && wbDst == stg[STG_R1].sb) ? res : rf[stg[STG_R1].sb];

    // ********************************
    // pipeline registers
    // ********************************
    // everything stands still while the final stage is held
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int k = 0; k < NSTAGE; k++) begin
                stg[k] <= '0;
            end
        end else if (ce && !hold) begin
            for (int k = STG_E3; k > STG_R2; k--) begin
                stg[k] <= stg[k-1];
            end
            stg[STG_R2] <= advR1 ? {stg[STG_R1].v, stg[STG_R1].op, stg[STG_R1].dst,
                                    stg[STG_R1].sa, stg[STG_R1].sb, opA, opB} : '0;
            if (take) begin
                stg[STG_R1] <= {1'b1, lnk.issueOp, lnk.issueDst, lnk.issueSrcA,
                                lnk.issueSrcB, lnk.issueData, 32'h0};
            end else if (advR1) begin
                stg[STG_R1] <= '0;
            end
        end
    end

    // ********************************
    // register file, status and link outputs
    // ********************************
    // loads carry their data in operand a, so every write takes res
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int k = 0; k < NREG; k++) begin
                rf[k] <= 32'h0;
            end
            lnk.issueAck    <= 1'b0;
            lnk.retireValid <= 1'b0;
            lnk.retireOp    <= OP_NOP;
            lnk.moveData    <= 32'h0;
            lnk.floatStatus <= ST_RST;
        end else if (ce) begin
            lnk.issueAck    <= take;
            lnk.retireValid <= leave;
            lnk.retireOp    <= stg[STG_E3].op;
            if (wbEn) begin
                rf[wbDst] <= res;
            end
            if (leave && stg[STG_E3].op == OP_MOVE) begin
                lnk.moveData <= ea;
            end
            // flags are sticky and drive the interrupt lines directly
            if (leave && stg[STG_E3].op == OP_STW) begin
                lnk.floatStatus <= ea[ST_W-1:0];
            end else if (leave) begin
                lnk.floatStatus <= lnk.floatStatus | flg;
            end
        end
    end

endmodule

// ---- rtl/fhf_cpu_ctrl.sv ----
`timescale 1ns/1ps
module fhf_cpu_ctrl
    import fhf_pkg::*;
(
    input  wire  logic        ref_clk,
    input  wire  logic        sys_rst,
    input  wire  logic        ce,
    input  wire  logic        holdReq,
    input  wire  logic [31:0] paddr,
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [31:0] pwdata,
    output logic       [31:0] prdata,
    output logic              pready,
    output logic              pslverr,
    output logic              irq,
    fhf_link_if.cpu           lnk
);

    // ********************************
    // sequencer states
    // ********************************
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,                 // wait for a command
        S_ISSUE = 5'b00010,                 // offer the command until taken
        S_WAIT  = 5'b00100,                 // wait for the estimate to retire
        S_REST  = 5'b01000,                 // offer the status restore
        S_DRAIN = 5'b10000                  // wait for the restore to retire
    } fhf_seq_e;

    fhf_seq_e          state;               // sequencer
    logic              cmdPend;             // a command waits to be sent
    fhf_op_e           cmdOp;               // command fields
    logic [RIDX_W-1:0] cmdDst;
    logic [RIDX_W-1:0] cmdSa;
    logic [RIDX_W-1:0] cmdSb;
    logic [REG_W-1:0]  dataReg;             // operand for loads and status writes
    logic [REG_W-1:0]  resultReg;           // last moved value
    logic [IRQ_W-1:0]  irqStat;             // sticky events
    logic [IRQ_W-1:0]  irqMask;             // enables for irq
    logic [ST_W-1:0]   savedSt;             // status pushed around an estimate
    logic [ST_W-1:0]   prevFlags;           // flags one cycle ago, for edges
    logic              estBusy;             // flag lines masked off
    logic [2:0]        slotCnt;             // delay slots still owed

    // ********************************
    // apb decode
    // ********************************
    wire        acc     = psel & penable;
    wire        apbDone = acc & pready;     // the edge where the transfer completes
    wire [7:0]  aLow    = paddr[7:0];
    wire        hiZero  = paddr[31:8] == 24'h0;
    wire        hitCmd  = hiZero & (aLow == A_CMD);
    wire        hitData = hiZero & (aLow == A_DATA);
    wire        hitRes  = hiZero & (aLow == A_RESULT);
    wire        hitStat = hiZero & (aLow == A_STATUS);
    wire        hitIrq  = hiZero & (aLow == A_IRQSTAT);
    wire        hitMask = hiZero & (aLow == A_IRQMASK);
    wire        mapped  = hitCmd | hitData | hitRes | hitStat | hitIrq | hitMask;
    // a command written while one still waits is refused with an error
    wire        badCmd  = hitCmd & pwrite & cmdPend;
    // follow the error answer already given, so accept and refuse never disagree
    wire        wrCmd   = apbDone & pwrite & hitCmd & ~pslverr;
    wire        rdIrq   = apbDone & ~pwrite & hitIrq;
    wire [31:0] rdMux   = hitCmd  ? {17'h0, cmdSb, 1'b0, cmdSa, 1'b0, cmdDst, cmdOp} :
                          hitData ? dataReg :
                          hitRes  ? resultReg :
                          hitStat ? {28'h0, estBusy, cmdPend, lnk.floatStatus} :
                          hitIrq  ? {28'h0, irqStat} :
                          hitMask ? {28'h0, irqMask} : 32'h0;

    // ********************************
    // command checks
    // ********************************
    // estimates whose data register is zero, or negative for the inverse root, are refused
    wire estOp   = fhf_is_est(cmdOp);
    wire refuse  = estOp & ((dataReg == 32'h0) |
                            (cmdOp == OP_ISQ & dataReg[REG_W-1]));
    // a move waits until the producer's delay slots are spent
    wire slotWait = (cmdOp == OP_MOVE) & (slotCnt != 3'h0);
    wire producer = lnk.issueOp inside {OP_MUL, OP_ADD};
    wire retEst   = lnk.retireValid & fhf_is_est(lnk.retireOp);
    wire retRest  = lnk.retireValid & (lnk.retireOp == OP_STW);

    // ********************************
    // interrupt events
    // ********************************
    // flag rises are not seen while an estimate's flags are unreliable
    wire [ST_W-1:0]  flagRise = lnk.floatStatus & ~prevFlags & {ST_W{~estBusy}};
    wire             moveEv   = lnk.retireValid & (lnk.retireOp == OP_MOVE);
    wire             refEv    = (state == S_IDLE) & cmdPend & refuse;
    wire [IRQ_W-1:0] setEv    = {refEv, flagRise[ST_LVF], flagRise[ST_LUF], moveEv};
    // a read clears only the bits it returned; an event landing after the
    // data was captured would otherwise be lost
    wire [IRQ_W-1:0] keep     = rdIrq ? (irqStat & ~prdata[IRQ_W-1:0]) : irqStat;

    // ********************************
    // apb slave: answer one cycle into the access phase
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (ce) begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & (~mapped | badCmd);
            prdata  <= (acc & ~pready & ~pwrite) ? rdMux : 32'h0;
        end
    end

    // ********************************
    // software registers and events
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dataReg   <= 32'h0;
            resultReg <= 32'h0;
            irqStat   <= IRQ_RST;
            irqMask   <= IRQ_RST;
            prevFlags <= ST_RST;
            irq       <= 1'b0;
        end else if (ce) begin
            if (apbDone && pwrite && hitData) begin
                dataReg <= pwdata;
            end
            if (apbDone && pwrite && hitMask) begin
                irqMask <= pwdata[IRQ_W-1:0];
            end
            if (moveEv) begin
                resultReg <= lnk.moveData;
            end
            // pending bits are only released by reading the whole register
            irqStat   <= keep | setEv;
            prevFlags <= lnk.floatStatus;
            irq       <= |(irqStat & irqMask);
        end
    end

    // ********************************
    // sequencer
    // ********************************
    // an estimate runs as push status, mask lines, issue, restore, unmask
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state          <= S_IDLE;
            cmdPend        <= 1'b0;
            cmdOp          <= OP_NOP;
            cmdDst         <= 3'h0;
            cmdSa          <= 3'h0;
            cmdSb          <= 3'h0;
            savedSt        <= ST_RST;
            estBusy        <= 1'b0;
            slotCnt        <= 3'h0;
            lnk.issueValid <= 1'b0;
            lnk.issueOp    <= OP_NOP;
            lnk.issueDst   <= 3'h0;
            lnk.issueSrcA  <= 3'h0;
            lnk.issueSrcB  <= 3'h0;
            lnk.issueData  <= 32'h0;
            lnk.e3Hold     <= 1'b0;
        end else if (ce) begin
            lnk.e3Hold <= holdReq;
            if (slotCnt != 3'h0) begin
                slotCnt <= slotCnt - 3'h1;
            end
            if (wrCmd) begin
                cmdPend <= 1'b1;
                cmdOp   <= fhf_op_e'(pwdata[CMD_OP_LSB +: 4]);
                cmdDst  <= pwdata[CMD_DST_LSB +: RIDX_W];
                cmdSa   <= pwdata[CMD_SA_LSB +: RIDX_W];
                cmdSb   <= pwdata[CMD_SB_LSB +: RIDX_W];
            end
            case (state)
                S_IDLE: begin
                    if (cmdPend && refuse) begin
                        cmdPend <= 1'b0;
                    end else if (cmdPend && !slotWait) begin
                        if (estOp) begin
                            savedSt <= lnk.floatStatus;
                            estBusy <= 1'b1;
                        end
                        lnk.issueValid <= 1'b1;
                        lnk.issueOp    <= cmdOp;
                        lnk.issueDst   <= cmdDst;
                        lnk.issueSrcA  <= cmdSa;
                        lnk.issueSrcB  <= cmdSb;
                        lnk.issueData  <= dataReg;
                        state          <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    if (lnk.issueAck) begin
                        lnk.issueValid <= 1'b0;
                        cmdPend        <= 1'b0;
                        if (producer) begin
                            slotCnt <= DELAY_SLOTS;
                        end
                        state <= fhf_is_est(lnk.issueOp) ? S_WAIT : S_IDLE;
                    end
                end
                S_WAIT: begin
                    // the estimate's flags are overwritten with the saved copy
                    if (retEst) begin
                        lnk.issueValid <= 1'b1;
                        lnk.issueOp    <= OP_STW;
                        lnk.issueData  <= {30'h0, savedSt};
                        state          <= S_REST;
                    end
                end
                S_REST: begin
                    if (lnk.issueAck) begin
                        lnk.issueValid <= 1'b0;
                        state          <= S_DRAIN;
                    end
                end
                S_DRAIN: begin
                    // lines are listened to again only once the flags are put back
                    if (retRest) begin
                        estBusy <= 1'b0;
                        state   <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- tb/fhf_link_assertions.sv ----
`timescale 1ns/1ps
// ****************
// link checker: both ends watched from the wire
// ****************
module fhf_link_assertions
    import fhf_pkg::*;
(
    input wire logic             ref_clk,
    input wire logic             sys_rst,
    input wire logic             issueValid,
    input wire logic             issueAck,
    input wire logic             e3Hold,
    input wire logic             retireValid,
    input wire fhf_op_e          retireOp,
    input wire logic [REG_W-1:0] moveData,
    input wire logic [ST_W-1:0]  floatStatus
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // a held final stage lets nothing out, so no flag may move either
    a_hold_no_retire: assert property (e3Hold |=> !retireValid)
        else $error("instruction retired while the final stage was held");
    a_hold_flags_kept: assert property (e3Hold |=> $stable(floatStatus))
        else $error("status flags moved while the final stage was held");
    a_flags_at_retire: assert property ($changed(floatStatus) |-> retireValid)
        else $error("status flags changed with no retire");
    a_flags_sticky: assert property (|($past(floatStatus) & ~floatStatus)
        |-> retireValid && retireOp == OP_STW)
        else $error("status flag fell without a status write");
    a_move_data_cause: assert property ($changed(moveData)
        |-> retireValid && retireOp == OP_MOVE)
        else $error("move data changed without a move retire");
    a_ack_one_cycle: assert property (issueAck |=> !issueAck)
        else $error("issue taken on two cycles in a row");
    a_ack_needs_req: assert property (issueAck |-> $past(issueValid))
        else $error("issue taken with no request");
    a_req_holds: assert property (issueValid && !issueAck |=> issueValid)
        else $error("request dropped before it was taken");
    // the estimate flags are thrown away by a status restore close behind it
    a_est_restore: assert property (retireValid && fhf_is_est(retireOp)
        |-> ##[5:60] (retireValid && retireOp == OP_STW))
        else $error("no status restore after an estimate");
endmodule

// ---- tb/fhf_bench.sv ----
`timescale 1ns/1ps
// ****************
// bench: cpu end and device end joined by the link, driven over apb
// ****************
module fhf_bench
    import fhf_pkg::*;
;
    logic        ref_clk   = 1'b0;  // 50 MHz
    logic        sys_rst   = 1'b1;
    logic        holdReq   = 1'b0;  // final-stage stall request
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [31:0] paddr     = 32'h0;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] q         = 32'h0;  // last read data
    logic [31:0] acc       = 32'h0;  // irq status gathered while waiting
    logic        err       = 1'b0;   // last slave error
    int          bad_count = 0;
    int          n_checks  = 0;
    always #10 ref_clk = ~ref_clk;
    fhf_link_if lnk ();
    fhf_fpu_pipe u_fhf_fpu_pipe (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1), .lnk(lnk.dev));
    fhf_cpu_ctrl u_fhf_cpu_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1),
        .holdReq(holdReq), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .lnk(lnk.cpu));
    fhf_link_assertions u_fhf_link_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .issueValid(lnk.issueValid), .issueAck(lnk.issueAck), .e3Hold(lnk.e3Hold),
        .retireValid(lnk.retireValid), .retireOp(lnk.retireOp), .moveData(lnk.moveData),
        .floatStatus(lnk.floatStatus));
    // one apb transfer; pready is read before the edge's own updates land
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // a second command while one is pending would be refused, so wait first
    task automatic cmd(input fhf_op_e op, input logic [2:0] d, s, input logic [31:0] v);
        xfer(1'b0, A_STATUS, 32'h0);
        while (q[2] !== 1'b0) xfer(1'b0, A_STATUS, 32'h0);
        xfer(1'b1, A_DATA, v);
        xfer(1'b1, A_CMD, {17'h0, s, 1'b0, s, 1'b0, d, op});
    endtask
    // wait for the move to retire, then compare what it carried out
    task automatic fin(input logic [31:0] e);
        acc = 32'h0;
        while (acc[IRQ_MOVE] !== 1'b1) begin
            xfer(1'b0, A_IRQSTAT, 32'h0);
            acc = acc | q;
        end
        xfer(1'b0, A_RESULT, 32'h0);
        chk("result", e, q);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        cmd(OP_LOAD, 3'h1, 3'h0, 32'h6);
        cmd(OP_LOAD, 3'h2, 3'h0, 32'h7);
        cmd(OP_MUL, 3'h3, 3'h1, 32'h0);
        cmd(OP_MOVE, 3'h0, 3'h3, 32'h0);
        fin(32'h24);
        $display("test interlock done");
        holdReq <= 1'b1;
        cmd(OP_MUL, 3'h5, 3'h2, 32'h0);
        cmd(OP_MOVE, 3'h0, 3'h5, 32'h0);
        repeat (20) @(posedge ref_clk);
        xfer(1'b1, A_CMD, 32'h0);
        chk("busy cmd", 32'h1, {31'h0, err});
        xfer(1'b0, A_IRQSTAT, 32'h0);
        chk("frozen", 32'h0, q & 32'h1);
        xfer(1'b0, A_RESULT, 32'h0);
        chk("stale", 32'h24, q);
        holdReq <= 1'b0;
        fin(32'h31);
        $display("test stall done");
        cmd(OP_LOAD, 3'h4, 3'h0, 32'h10);
        cmd(OP_RCP, 3'h5, 3'h4, 32'h10);
        cmd(OP_MOVE, 3'h0, 3'h5, 32'h0);
        fin(32'h0FFFFFFF);
        chk("rcp flags", 32'h0, acc & 32'h6);
        cmd(OP_ISQ, 3'h6, 3'h4, 32'h10);
        cmd(OP_MOVE, 3'h0, 3'h6, 32'h0);
        fin(32'h3FFFFFFF);
        chk("isq flags", 32'h0, acc & 32'h6);
        $display("test estimate done");
        cmd(OP_ISQ, 3'h6, 3'h4, 32'h80000010);
        cmd(OP_RCP, 3'h5, 3'h4, 32'h0);
        cmd(OP_NOP, 3'h0, 3'h0, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("masked irq", 32'h0, {31'h0, irq});
        xfer(1'b1, A_IRQMASK, 32'h8);
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, irq});
        xfer(1'b0, A_IRQSTAT, 32'h0);
        chk("refused", 32'h8, q & 32'h8);
        repeat (3) @(posedge ref_clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("test refuse done");
        cmd(OP_LOAD, 3'h7, 3'h0, 32'h10001);
        cmd(OP_MUL, 3'h7, 3'h7, 32'h0);
        cmd(OP_MOVE, 3'h0, 3'h7, 32'h0);
        fin(32'h00020001);
        chk("ovf event", 32'h4, acc & 32'h4);
        xfer(1'b0, A_STATUS, 32'h0);
        chk("ovf flag", 32'h2, q & 32'h3);
        cmd(OP_STW, 3'h0, 3'h0, 32'h0);
        cmd(OP_MOVE, 3'h0, 3'h7, 32'h0);
        fin(32'h00020001);
        xfer(1'b0, A_STATUS, 32'h0);
        chk("flags cleared", 32'h0, q & 32'h3);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test flags done");
        conclude();
    end
    // the tests need well under a thousand cycles; this is ample
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("[FAIL] watchdog expected done seen hung");
        conclude();
    end
endmodule
